// *** crc_checksum_engine.sv ***
// checksum engine: byte-serial crc over 8/16/32-bit data writes
// assumes writes come from processor or dma as valid/ready on sys_clk
`timescale 1ns/100ps
module crc_checksum_engine (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] poly_sel,
    input wire logic data_cmpl,
    input wire logic data_byte_rev,
    input wire logic data_bit_rev,
    input wire logic sum_cmpl,
    input wire logic sum_byte_rev,
    input wire logic sum_bit_rev,
    input wire logic seed_load,
    input wire logic [31:0] seed_value,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [1:0] wr_size,
    input wire logic [31:0] wr_data,
    output logic [31:0] checksum,
    output logic busy
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // reverse bits within each byte
    function automatic logic [31:0] bit_rev8(input logic [31:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[(i / 8) * 8 + 7 - (i % 8)];
        end
        return r;
    endfunction : bit_rev8

    // swap byte order over the given width (16 or 32 bits)
    function automatic logic [31:0] byte_swap(input logic [31:0] v, input logic wide);
        logic [31:0] r;
        r = '0;
        if (wide) begin
            r = {v[7:0], v[15:8], v[23:16], v[31:24]};
        end else begin
            r = {v[31:16], v[7:0], v[15:8]};
        end
        return r;
    endfunction : byte_swap

    // ------------------------------------------------------------
    // input buffer
    // ------------------------------------------------------------
    logic buf_valid;
    logic buf_ready;
    logic [33:0] buf_data;

    // writes queue here so a busy core stalls the source, not drops words
    crc_skid u_skid (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_size, wr_data}),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // ------------------------------------------------------------
    // core state
    // ------------------------------------------------------------
    crc_pkg::crc_state_t state_r;
    crc_pkg::crc_state_t state_nxt;
    logic [31:0] crc_r;
    logic [31:0] crc_nxt;
    logic [31:0] shift_r;
    logic [31:0] shift_nxt;
    logic [2:0] left_r;
    logic [2:0] left_nxt;
    logic [31:0] poly;
    logic is32;
    logic [31:0] din;
    logic [2:0] nbytes;
    logic [31:0] step_crc;
    logic [31:0] sum_raw;
    logic [31:0] sum_x;

    // polynomial selection
    always_comb begin
        is32 = (poly_sel == crc_pkg::POLY_CRC32);
        if (poly_sel == crc_pkg::POLY_CRC32) begin
            poly = crc_pkg::POLY_CRC32_VAL;
        end else if (poly_sel == crc_pkg::POLY_CCITT) begin
            poly = crc_pkg::POLY_CCITT_VAL;
        end else begin
            poly = crc_pkg::POLY_CRC16_VAL;
        end
    end

    // input data transforms and byte count, low bytes taken first
    always_comb begin
        din = buf_data[31:0];
        if (buf_data[33:32] == crc_pkg::SIZE_BYTE) begin
            nbytes = crc_pkg::BYTES_BYTE;
            din = {24'h000000, din[7:0]};
        end else if (buf_data[33:32] == crc_pkg::SIZE_HALF) begin
            nbytes = crc_pkg::BYTES_HALF;
            din = {16'h0000, din[15:0]};
            if (data_byte_rev) begin
                din = byte_swap(din, 1'b0);
            end
        end else begin
            nbytes = crc_pkg::BYTES_WORD;
            if (data_byte_rev) begin
                din = byte_swap(din, 1'b1);
            end
        end
        if (data_bit_rev) begin
            din = bit_rev8(din);
        end
        if (data_cmpl) begin
            din = ~din;
        end
    end

    // one byte of message folded into the remainder, msb-first per byte
    always_comb begin
        logic [31:0] c;
        logic [7:0] b;
        logic fb;
        fb = 1'b0;
        c = crc_r;
        b = shift_r[7:0];
        for (int i = 7; i >= 0; i--) begin
            fb = (is32 ? c[31] : c[15]) ^ b[i];
            c = {c[30:0], 1'b0};
            if (fb) begin
                c = c ^ poly;
            end
        end
        step_crc = is32 ? c : (c & crc_pkg::MASK16);
    end

    // sequencer: one load cycle, then one byte per cycle, so 2/3/5 cycles per size
    always_comb begin
        state_nxt = state_r;
        crc_nxt = crc_r;
        shift_nxt = shift_r;
        left_nxt = left_r;
        buf_ready = 1'b0;
        case (state_r)
            crc_pkg::ST_IDLE: begin
                if (seed_load) begin
                    crc_nxt = is32 ? seed_value : (seed_value & crc_pkg::MASK16);
                end else if (buf_valid) begin
                    buf_ready = 1'b1;
                    shift_nxt = din;
                    left_nxt = nbytes;
                    state_nxt = crc_pkg::ST_RUN;
                end
            end
            crc_pkg::ST_RUN: begin
                crc_nxt = step_crc;
                shift_nxt = {8'h00, shift_r[31:8]};
                left_nxt = left_r - 3'h1;
                if (left_r == crc_pkg::BYTES_BYTE) begin
                    state_nxt = crc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = crc_pkg::ST_IDLE;
            end
        endcase
    end

    // core registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= crc_pkg::ST_IDLE;
            crc_r <= crc_pkg::SEED_RESET;
            shift_r <= '0;
            left_r <= '0;
        end else begin
            state_r <= state_nxt;
            crc_r <= crc_nxt;
            shift_r <= shift_nxt;
            left_r <= left_nxt;
        end
    end

    // ------------------------------------------------------------
    // result transforms
    // ------------------------------------------------------------
    logic [31:0] sum_r;
    logic [31:0] sum_nxt;

    // checksum output transforms over 16 or 32 bits
    always_comb begin
        sum_raw = crc_r;
        sum_x = sum_raw;
        if (sum_byte_rev) begin
            sum_x = byte_swap(sum_x, is32);
        end
        if (sum_bit_rev) begin
            sum_x = bit_rev8(sum_x);
        end
        if (sum_cmpl) begin
            sum_x = ~sum_x;
        end
        sum_nxt = is32 ? sum_x : (sum_x & crc_pkg::MASK16);
    end

    // registered result
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_r <= crc_pkg::SEED_RESET;
        end else begin
            sum_r <= sum_nxt;
        end
    end

    assign checksum = sum_r;
    assign busy = (state_r == crc_pkg::ST_RUN) || buf_valid;
endmodule : crc_checksum_engine

// *** crc_checksum_engine_assertions.sv ***
// checker for the checksum engine ports
// assumes one clock domain; bound to every engine instance
`timescale 1ns/100ps
module crc_checksum_engine_assertions (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] poly_sel,
    input wire logic data_cmpl,
    input wire logic data_byte_rev,
    input wire logic data_bit_rev,
    input wire logic sum_cmpl,
    input wire logic sum_byte_rev,
    input wire logic sum_bit_rev,
    input wire logic seed_load,
    input wire logic [31:0] seed_value,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [1:0] wr_size,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] checksum,
    input wire logic busy
);
    // ----------------------------------------
    // timing and result checks
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic quiet;
    // a write taken by an idle engine, and a cycle with nothing new arriving
    assign take = wr_valid && wr_ready && !busy && !seed_load;
    assign quiet = !wr_valid && !seed_load;
    a_idle_ready: assert property (!busy |-> wr_ready)
        else $error("ready low while idle");
    a_byte_done: assert property ((take && wr_size == crc_pkg::SIZE_BYTE) ##1 quiet [*4] |-> !busy)
        else $error("byte update too slow");
    a_half_done: assert property ((take && wr_size == crc_pkg::SIZE_HALF) ##1 quiet [*5] |-> !busy)
        else $error("half update too slow");
    a_word_done: assert property ((take && wr_size == crc_pkg::SIZE_WORD) ##1 quiet [*7] |-> !busy)
        else $error("word update too slow");
    a_half_runs: assert property (take && wr_size == crc_pkg::SIZE_HALF |=> busy [*2])
        else $error("half update ended early");
    a_word_runs: assert property (take && wr_size == crc_pkg::SIZE_WORD |=> busy [*4])
        else $error("word update ended early");
    a_sum_hold: assert property ((!busy && !seed_load && $stable({poly_sel, sum_cmpl, sum_byte_rev,
        sum_bit_rev})) [*4] |-> $stable(checksum))
        else $error("checksum moved while idle");
    a_upper_zero: assert property ((poly_sel != crc_pkg::POLY_CRC32 && !busy && !seed_load) [*4]
        |-> checksum[31:16] == 16'h0)
        else $error("upper half set for short poly");
endmodule : crc_checksum_engine_assertions

bind crc_checksum_engine crc_checksum_engine_assertions chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .poly_sel(poly_sel), .data_cmpl(data_cmpl), .data_byte_rev(data_byte_rev),
    .data_bit_rev(data_bit_rev), .sum_cmpl(sum_cmpl), .sum_byte_rev(sum_byte_rev),
    .sum_bit_rev(sum_bit_rev), .seed_load(seed_load), .seed_value(seed_value),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_size(wr_size), .wr_data(wr_data),
    .checksum(checksum), .busy(busy));

// *** crc_dma_model.sv ***
// write source standing in for the dma engine
// assumes the bench fills q between clock edges
`timescale 1ns/100ps
module crc_dma_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic slow,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [1:0] wr_size,
    output logic [31:0] wr_data
);
    // ----------------------------------------
    // queued writes, held until taken
    // ----------------------------------------
    logic [33:0] q[$];
    // slow inserts one idle cycle between writes; idle data toggles
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_valid <= 1'h0;
            wr_size <= 2'h0;
            wr_data <= 32'h0;
        end else if (!wr_valid || wr_ready) begin
            if (q.size() != 0 && !(slow && wr_valid)) begin
                {wr_size, wr_data} <= q.pop_front();
                wr_valid <= 1'h1;
            end else begin
                wr_valid <= 1'h0;
                wr_data <= ~wr_data;
            end
        end
    end
endmodule : crc_dma_model

// *** crc_pkg.sv ***
// package for the checksum engine: polynomials, mode encodings, widths
// assumes one synchronous clock domain and a plain-port data source
//
// Notes on behaviour
// - two 16-bit polynomials selectable: classic 0x8005 and ccitt 0x1021
// - 32-bit polynomial 0x04c11db7 selectable instead of the 16-bit ones
// - complement, byte reverse, bit reverse selectable for data and for checksum
// - byte, half-word, word input sizes; only bytes of the written size used
// - software loads any seed into the accumulator before computing
// - one byte finishes in 2 cycles, one word in 5 cycles (one load cycle, then one per byte)
// - result is 16 bits for 16-bit polynomials, 32 bits for the 32-bit one
// - dma delivers a block as consecutive writes, accepted without processor
package crc_pkg;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int BYTES_W = 3;
    localparam logic [1:0] POLY_CRC16 = 2'h0;
    localparam logic [1:0] POLY_CCITT = 2'h1;
    localparam logic [1:0] POLY_CRC32 = 2'h2;
    localparam logic [31:0] POLY_CRC16_VAL = 32'h00008005;
    localparam logic [31:0] POLY_CCITT_VAL = 32'h00001021;
    localparam logic [31:0] POLY_CRC32_VAL = 32'h04c11db7;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [2:0] BYTES_BYTE = 3'h1;
    localparam logic [2:0] BYTES_HALF = 3'h2;
    localparam logic [2:0] BYTES_WORD = 3'h4;
    localparam logic [31:0] SEED_RESET = 32'h00000000;
    localparam logic [31:0] MASK16 = 32'h0000ffff;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } crc_state_t;
endpackage : crc_pkg

// *** crc_skid.sv ***
// two-entry buffer between data source and checksum core
// assumes source and sink share sys_clk
`timescale 1ns/100ps
module crc_skid (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [33:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [33:0] out_data
);
    logic [33:0] mem_r [2];
    logic [33:0] mem_nxt [2];
    logic rd_r;
    logic rd_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic push;
    logic pop;

    // handshake and read data
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and storage update
    always_comb begin
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = ~wr_r;
        end
        if (pop) begin
            rd_nxt = ~rd_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule : crc_skid

// *** test_crc_checksum_engine.sv ***
// self-checking bench for the checksum engine
// assumes the dma model as write source
`timescale 1ns/100ps
module test_crc_checksum_engine;
    // ----------------------------------------
    // stimulus, reference and checks
    // ----------------------------------------
    logic sys_clk = 1'h0, reset_n = 1'h0, slow = 1'h0, refused = 1'h0;
    logic data_cmpl = 1'h0, sum_cmpl = 1'h0, seed_load = 1'h0, wr_valid, wr_ready, busy;
    logic data_byte_rev = 1'h0, data_bit_rev = 1'h0, sum_byte_rev = 1'h0, sum_bit_rev = 1'h0;
    logic [1:0] poly_sel = 2'h0, wr_size;
    logic [31:0] seed_value = 32'h0, exp_r = 32'h0, wr_data, checksum;
    int error_cnt = 0, checks_done = 0;
    crc_dma_model dma (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_size(wr_size), .wr_data(wr_data));
    crc_checksum_engine uut (.sys_clk(sys_clk), .reset_n(reset_n), .poly_sel(poly_sel),
        .data_cmpl(data_cmpl), .data_byte_rev(data_byte_rev), .data_bit_rev(data_bit_rev),
        .sum_cmpl(sum_cmpl), .sum_byte_rev(sum_byte_rev), .sum_bit_rev(sum_bit_rev),
        .seed_load(seed_load), .seed_value(seed_value),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_size(wr_size), .wr_data(wr_data),
        .checksum(checksum), .busy(busy));
    always #5 sys_clk = ~sys_clk;
    // remember that the buffer pushed back at least once
    always @(posedge sys_clk) if (wr_valid && !wr_ready) refused <= 1'h1;
    task check(input logic [31:0] seen, input logic [31:0] expd);
        checks_done++;
        if (seen !== expd) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check
    task conclude;
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    function automatic logic [31:0] mask(input logic [31:0] v);
        return (poly_sel == crc_pkg::POLY_CRC32) ? v : v & crc_pkg::MASK16;
    endfunction : mask
    // reference update: low byte first, msb first, no reflection
    task put(input logic [1:0] sz, input logic [31:0] d);
        logic [31:0] p, x, y;
        logic msb;
        p = poly_sel == 2'h2 ? crc_pkg::POLY_CRC32_VAL :
            poly_sel == 2'h1 ? crc_pkg::POLY_CCITT_VAL : crc_pkg::POLY_CRC16_VAL;
        x = d;
        if (data_byte_rev && sz == crc_pkg::SIZE_HALF) x = {16'h0, d[7:0], d[15:8]};
        if (data_byte_rev && sz == crc_pkg::SIZE_WORD) x = {d[7:0], d[15:8], d[23:16], d[31:24]};
        y = x;
        if (data_bit_rev) for (int j = 0; j < 32; j++) x[j] = y[j ^ 7];
        if (data_cmpl) x = ~x;
        for (int i = 0; i < (sz == 2'h0 ? 1 : sz == 2'h1 ? 2 : 4); i++) begin
            exp_r ^= {x[8 * i +: 8], 24'h0} >> (poly_sel == 2'h2 ? 0 : 16);
            repeat (8) begin
                msb = poly_sel == 2'h2 ? exp_r[31] : exp_r[15];
                exp_r = mask((exp_r << 1) ^ (msb ? p : 32'h0));
            end
        end
        dma.q.push_back({sz, d});
    endtask : put
    // bounded wait for an empty path, ends between edges
    task settle;
        int k;
        for (k = 0; k < 300 && (dma.q.size() != 0 || wr_valid || busy); k++) @(negedge sys_clk);
        if (k == 300) begin
            error_cnt++;
            conclude();
        end
        repeat (3) @(negedge sys_clk);
    endtask : settle
    // expected checksum: byte reverse, bit reverse within bytes, complement
    function automatic logic [31:0] res;
        logic [31:0] v, w;
        v = mask(exp_r);
        if (sum_byte_rev) v = (poly_sel == crc_pkg::POLY_CRC32) ?
            {v[7:0], v[15:8], v[23:16], v[31:24]} : {16'h0, v[7:0], v[15:8]};
        w = v;
        if (sum_bit_rev) for (int j = 0; j < 32; j++) v[j] = w[j ^ 7];
        return mask(sum_cmpl ? ~v : v);
    endfunction : res
    task seed(input logic [31:0] s);
        @(posedge sys_clk);
        seed_value <= s;
        seed_load <= 1'h1;
        @(posedge sys_clk);
        seed_load <= 1'h0;
        exp_r = mask(s);
        settle();
        check(checksum, res());
    endtask : seed
    // all polynomials and sizes, then complement, then a refused burst
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk);
            poly_sel <= m[1:0];
            seed(32'hffffffff);
            put(crc_pkg::SIZE_BYTE, 32'hffffff31);
            put(crc_pkg::SIZE_HALF, 32'hffff3332);
            put(crc_pkg::SIZE_WORD, 32'h37363534);
            settle();
            check(checksum, res());
        end
        @(posedge sys_clk);
        data_cmpl <= 1'h1;
        sum_cmpl <= 1'h1;
        slow <= 1'h1;
        {data_byte_rev, data_bit_rev, sum_byte_rev, sum_bit_rev} <= 4'hf;
        seed(32'h1234abcd);
        put(crc_pkg::SIZE_WORD, 32'ha5c3e10f);
        put(crc_pkg::SIZE_HALF, 32'h00005aa5);
        settle();
        check(checksum, res());
        // spare selector code, isolated writes of each size, reversal kept on
        @(posedge sys_clk);
        {data_cmpl, sum_cmpl, slow, poly_sel} <= 5'h3;
        seed(32'h0000c0de);
        put(crc_pkg::SIZE_BYTE, 32'hffffff5a);
        settle();
        put(crc_pkg::SIZE_HALF, 32'h00009c3e);
        settle();
        put(crc_pkg::SIZE_WORD, 32'h0f1e2d3c);
        settle();
        check(checksum, res());
        @(posedge sys_clk);
        {data_cmpl, sum_cmpl, slow, poly_sel, data_byte_rev, data_bit_rev, sum_byte_rev,
            sum_bit_rev} <= 9'h010;
        seed(32'h0000ffff);
        for (int i = 1; i < 7; i++) put(crc_pkg::SIZE_WORD, 32'h01020304 * i);
        settle();
        check(checksum, res());
        check({31'h0, refused}, 32'h1);
        conclude();
    end
endmodule : test_crc_checksum_engine
